// ### src/oag_pkg.sv
/*
  Package for the operand address generator: modes, widths, constants and
  the request and answer structs.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
`default_nettype none
package oag_pkg;
  localparam logic [3:0] OAG_BANK0 = 4'h0;
  localparam logic [3:0] OAG_BANK1 = 4'h1;
  localparam logic [3:0] OAG_BANK15 = 4'hf;
  localparam logic [7:0] OAG_FMEM_LO_BASE = 8'hb0;
  localparam logic [7:0] OAG_FMEM_HI_BASE = 8'hf0;
  localparam logic [7:0] OAG_PMEM_BASE = 8'hc0;
  localparam logic [13:0] OAG_ADDR_MAX_BIG = 14'h3f7f;
  localparam logic [13:0] OAG_ADDR_MAX_SMALL = 14'h2f7f;
  localparam logic [13:0] OAG_TADDR_LO = 14'h0020;
  localparam logic [13:0] OAG_TADDR_HI = 14'h007f;
  localparam logic [3:0] OAG_BSR_RESET = 4'h0;
  localparam logic bank_enable_flag_RESET = 1'b0;
  localparam int OAG_NREGS = 8;

  typedef enum logic [3:0] {
    OAG_M_NONE = 4'b0000,
    OAG_M_DIRECT = 4'b0001,
    OAG_M_HL = 4'b0010,
    OAG_M_DE = 4'b0011,
    OAG_M_DL = 4'b0100,
    OAG_M_FMEM = 4'b0101,
    OAG_M_PMEM = 4'b0110,
    OAG_M_FULL = 4'b0111,
    OAG_M_PAGE = 4'b1000,
    OAG_M_SHORT = 4'b1001,
    OAG_M_REL = 4'b1010,
    OAG_M_TABLE = 4'b1011
  } oag_mode_t;

  typedef struct packed {
    oag_mode_t mode;
    logic [13:0] operand;
    logic wide;
  } oag_req_t;

  typedef struct packed {
    logic dvalid;
    logic [11:0] daddr;
    logic pvalid;
    logic [13:0] paddr;
    logic fault;
  } oag_ans_t;
endpackage
`default_nettype wire

// ### src/oag_regfile.sv
/*
  Eight 4-bit working registers, written singly or as 8-bit pairs,
  read out as registered pairs.
  Assumes writes and reads come from the core on the same clock.
*/
`default_nettype none
module oag_regfile
  import oag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic wr_nib,
  input wire logic wr_pair,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  output logic [31:0] pairs_ff
);
  typedef struct packed {
    logic [OAG_NREGS-1:0][3:0] r;
    logic [31:0] q;
  } oag_rf_t;
  oag_rf_t st_ff;
  oag_rf_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // pair n: high nibble reg 2n+1, low reg 2n; pair 0 is accumulator_pair
    for (int i = 0; i < OAG_NREGS; i++) begin
      if (wr_nib && wr_idx == 3'(i)) begin
        nxt_st.r[i] = wr_data[3:0];
      end
      if (wr_pair && wr_idx[2:1] == 2'(i / 2)) begin
        nxt_st.r[i] = (i % 2 == 1) ? wr_data[7:4] : wr_data[3:0];
      end
    end
    nxt_st.q = st_ff.r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
  assign pairs_ff = st_ff.q;

  AST_PAIR_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && wr_pair && !wr_nib ##1 clk_en [*1] |=>
      pairs_ff[{$past(wr_idx[2:1], 2), 3'b000} +: 8] == $past(wr_data, 2))
    else $error("pair write not seen");
endmodule
`default_nettype wire

// ### src/oag_top.sv
/*
  Operand address generator: decodes operand fields into 12-bit data
  addresses and 14-bit program addresses, and decodes bit, immediate and
  port fields.
  Assumes the fetch logic presents one request per machine cycle.
*/
// Operation
// - bank off: low half bank 0, high 15 (direct only; HL pointer uses bank 0 for both halves)
// - bank on: select register, banks 0/1/15
// - second and mixed pointers always bank 0
// - fixed-area bit operands in bank 15 only
// - peripheral bit operands FC0H-FFFH, bank 15
// - relative target minus 15..1, plus 2..16
// - page branch keeps PC bits 13,12
// - full address limit per ROM size
// - short call confined to 0000H-07FFH
// - vector entries even, 20H to 7FH
// - eight nibble registers, four pairs
// - bit position is a 2-bit field
// - immediates 4-bit nibble, 8-bit pair
// - port select is 0 to 7
`default_nettype none
module oag_top
  import oag_pkg::*;
#(
  parameter bit BIG_ROM = 1'b1
)(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire oag_req_t req,
  input wire logic req_valid,
  input wire logic [13:0] pc,
  input wire logic [7:0] pointer_lo,
  input wire logic bank_flag_wr,
  input wire logic bank_flag_in,
  input wire logic bank_sel_wr,
  input wire logic [3:0] bank_sel_in,
  input wire logic reg_wr_nib,
  input wire logic reg_wr_pair,
  input wire logic [2:0] reg_wr_idx,
  input wire logic [7:0] reg_wr_data,
  output oag_ans_t ans_ff,
  output logic [1:0] bit_pos_ff,
  output logic [3:0] nibble_immediate_ff,
  output logic [7:0] byte_immediate_ff,
  output logic [2:0] port_select_ff,
  output logic [3:0] active_bank_ff,
  output logic bank_enable_flag_ff,
  output logic [31:0] pairs_ff
);
  typedef struct packed {
    logic bank_en;
    logic [3:0] bank_sel;
    oag_ans_t ans;
    logic [1:0] bitp;
    logic [3:0] n4;
    logic [7:0] n8;
    logic [2:0] port;
    logic [3:0] bank;
  } oag_st_t;
  oag_st_t st_ff;
  oag_st_t nxt_st;
  logic [13:0] lim;
  logic [3:0] mem_bank;
  logic [14:0] rel_sum;
  logic [4:0] rel_off;
  logic [5:0] rel_disp;

  always_comb begin
    nxt_st = st_ff;
    lim = BIG_ROM ? OAG_ADDR_MAX_BIG : OAG_ADDR_MAX_SMALL;
    rel_off = req.operand[4:0];
    // code 10h stands for +16: forward reach is one longer than back
    rel_disp = (rel_off == 5'h10) ? 6'h10 : {rel_off[4], rel_off};
    rel_sum = {1'b0, pc} + {{9{rel_disp[5]}}, rel_disp};
    if (!st_ff.bank_en) begin
      mem_bank = req.operand[7] ? OAG_BANK15 : OAG_BANK0;
    end else begin
      mem_bank = st_ff.bank_sel;
    end
    if (bank_flag_wr) begin
      nxt_st.bank_en = bank_flag_in;
    end
    // only banks 0, 1 and 15 are legal selections; others are ignored
    if (bank_sel_wr && (bank_sel_in == OAG_BANK0 || bank_sel_in == OAG_BANK1
        || bank_sel_in == OAG_BANK15)) begin
      nxt_st.bank_sel = bank_sel_in;
    end
    nxt_st.ans = '0;
    if (req_valid) begin
      nxt_st.bitp = req.operand[9:8];
      nxt_st.n4 = req.operand[3:0];
      nxt_st.n8 = req.operand[7:0];
      nxt_st.port = req.operand[2:0];
      case (req.mode)
        OAG_M_DIRECT: begin
          nxt_st.ans.dvalid = 1'b1;
          nxt_st.ans.daddr = {mem_bank, req.operand[7:0]};
          nxt_st.ans.fault = req.wide & req.operand[0];
          nxt_st.bank = mem_bank;
        end
        OAG_M_HL: begin
          nxt_st.ans.dvalid = 1'b1;
          nxt_st.ans.daddr = {st_ff.bank_en ? st_ff.bank_sel : OAG_BANK0,
                              pointer_lo};
          nxt_st.bank = st_ff.bank_en ? st_ff.bank_sel : OAG_BANK0;
        end
        OAG_M_DE, OAG_M_DL: begin
          nxt_st.ans.dvalid = 1'b1;
          nxt_st.ans.daddr = {OAG_BANK0, pointer_lo};
          nxt_st.bank = OAG_BANK0;
        end
        OAG_M_FMEM: begin
          nxt_st.ans.dvalid = 1'b1;
          nxt_st.ans.daddr = {OAG_BANK15, (req.operand[4] ? OAG_FMEM_HI_BASE
                              : OAG_FMEM_LO_BASE) | {4'h0,
                              req.operand[3:0]}};
          nxt_st.bank = OAG_BANK15;
        end
        OAG_M_PMEM: begin
          nxt_st.ans.dvalid = 1'b1;
          nxt_st.ans.daddr = {OAG_BANK15, OAG_PMEM_BASE | {2'b00,
                              req.operand[5:0]}};
          nxt_st.bank = OAG_BANK15;
        end
        OAG_M_FULL: begin
          nxt_st.ans.pvalid = 1'b1;
          nxt_st.ans.paddr = req.operand;
          nxt_st.ans.fault = req.operand > lim;
        end
        OAG_M_PAGE: begin
          nxt_st.ans.pvalid = 1'b1;
          nxt_st.ans.paddr = {pc[13:12], req.operand[11:0]};
          nxt_st.ans.fault = {pc[13:12], req.operand[11:0]} > lim;
        end
        OAG_M_SHORT: begin
          nxt_st.ans.pvalid = 1'b1;
          nxt_st.ans.paddr = {3'b000, req.operand[10:0]};
        end
        OAG_M_REL: begin
          nxt_st.ans.pvalid = 1'b1;
          nxt_st.ans.paddr = rel_sum[13:0];
          nxt_st.ans.fault = (rel_off == 5'h00)
                             || (rel_off == 5'h01);
        end
        OAG_M_TABLE: begin
          nxt_st.ans.pvalid = 1'b1;
          nxt_st.ans.paddr = {7'h00, req.operand[6:1], 1'b0};
          nxt_st.ans.fault = {7'h00, req.operand[6:1], 1'b0}
                             < OAG_TADDR_LO;
        end
        default: begin
          nxt_st.ans = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.bank_en <= bank_enable_flag_RESET;
      st_ff.bank_sel <= OAG_BSR_RESET;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign ans_ff = st_ff.ans;
  assign bit_pos_ff = st_ff.bitp;
  assign nibble_immediate_ff = st_ff.n4;
  assign byte_immediate_ff = st_ff.n8;
  assign port_select_ff = st_ff.port;
  assign active_bank_ff = st_ff.bank;
  assign bank_enable_flag_ff = st_ff.bank_en;

  oag_regfile u_rf (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .wr_nib(reg_wr_nib),
    .wr_pair(reg_wr_pair),
    .wr_idx(reg_wr_idx),
    .wr_data(reg_wr_data),
    .pairs_ff(pairs_ff)
  );

  sequence s_req(oag_mode_t m);
    clk_en && req_valid && req.mode == m;
  endsequence

  AST_BANK_OFF: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_DIRECT) ##0 !st_ff.bank_en |=>
      ans_ff.daddr[11:8] == ($past(req.operand[7]) ? 4'hf : 4'h0))
    else $error("bank-off mapping wrong");
  AST_BANK_ON: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_HL) ##0 st_ff.bank_en |=>
      ans_ff.daddr[11:8] == $past(st_ff.bank_sel))
    else $error("bank-on mapping wrong");
  AST_BANK_LEGAL: assert property (@(posedge ref_clk) disable iff (srst)
    st_ff.bank_sel == 4'h0 || st_ff.bank_sel == 4'h1
    || st_ff.bank_sel == 4'hf)
    else $error("illegal bank held");
  AST_BANK0_PTR: assert property (@(posedge ref_clk) disable iff (srst)
    (s_req(OAG_M_DE) or s_req(OAG_M_DL)) |=>
      ans_ff.dvalid && ans_ff.daddr[11:8] == 4'h0)
    else $error("pointer not bank 0");
  AST_FMEM: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_FMEM) |=> ans_ff.daddr[11:8] == 4'hf &&
      (ans_ff.daddr[7:4] == 4'hb || ans_ff.daddr[7:4] == 4'hf))
    else $error("fixed area out of range");
  AST_PMEM: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_PMEM) |=> ans_ff.daddr[11:6] == 6'h3f)
    else $error("peripheral area out of range");
  AST_REL: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_REL) |=> ans_ff.fault ||
      (ans_ff.paddr - $past(pc) <= 14'h10 && ans_ff.paddr - $past(pc) >= 14'h2)
      || ($past(pc) - ans_ff.paddr <= 14'hf && $past(pc) != ans_ff.paddr))
    else $error("relative target off");
  AST_PAGE: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_PAGE) |=> ans_ff.paddr[13:12] == $past(pc[13:12]))
    else $error("page bits changed");
  AST_SHORT: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_SHORT) |=> ans_ff.pvalid && ans_ff.paddr[13:11] == 3'h0)
    else $error("short call out of range");
  AST_TABLE: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_TABLE) |=> !ans_ff.paddr[0] && ans_ff.paddr <= 14'h7f)
    else $error("vector entry wrong");
  AST_FULL: assert property (@(posedge ref_clk) disable iff (srst)
    s_req(OAG_M_FULL) |=> ans_ff.fault == (ans_ff.paddr > lim))
    else $error("full range check wrong");
  AST_FIELDS: assert property (@(posedge ref_clk) disable iff (srst)
    clk_en && req_valid |=> bit_pos_ff == $past(req.operand[9:8]) &&
      port_select_ff == $past(req.operand[2:0]) &&
      byte_immediate_ff == $past(req.operand[7:0]))
    else $error("field decode wrong");
endmodule
`default_nettype wire

// ### tb/oag_pmem_model.sv
/*
  Program memory model: holds operand words and hands one to the decoder
  while rd is high.
  Assumes the bench loads rom and raises rd only with a fetch.
*/
`default_nettype none
module oag_pmem_model
  import oag_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rd,
  input wire logic [3:0] addr,
  output oag_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  oag_req_t rom [16];
  oag_req_t last = '0;
  always @(posedge ref_clk) begin
    if (rd) begin
      last <= rom[addr];
    end
  end
  // released bus shows the inverse of the last word
  assign req_out = rd ? rom[addr] : oag_req_t'(~last);
endmodule
`default_nettype wire

// ### tb/oag_top_tb.sv
/*
  Bench for the operand address generator: fetches operands through a
  program memory model and compares addresses and fields.
  Assumes the package and design files are compiled first.
*/
`default_nettype none
module oag_top_tb
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic rd = 1'b0;
  logic [3:0] fa = 4'h0;
  logic [13:0] pc = 14'h2abc;
  logic [7:0] pointer_lo = 8'h99;
  logic bank_flag_wr = 1'b0;
  logic bank_flag_in = 1'b0;
  logic bank_sel_wr = 1'b0;
  logic [3:0] bank_sel_in = 4'h0;
  logic reg_wr_nib = 1'b0;
  logic reg_wr_pair = 1'b0;
  logic [2:0] reg_wr_idx = 3'h0;
  logic [7:0] reg_wr_data = 8'h00;
  oag_req_t req;
  oag_ans_t ans_ff;
  logic [1:0] bit_pos_ff;
  logic [3:0] nibble_immediate_ff;
  logic [7:0] byte_immediate_ff;
  logic [2:0] port_select_ff;
  logic [3:0] active_bank_ff;
  logic bank_enable_flag_ff;
  logic [31:0] pairs_ff;
  int n_errors = 0;
  int samples_checked = 0;

  oag_pmem_model pm (.ref_clk(ref_clk), .rd(rd), .addr(fa), .req_out(req));
  oag_top #(.BIG_ROM(1'b1)) dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .req(req),
    .req_valid(req_valid),
    .pc(pc),
    .pointer_lo(pointer_lo),
    .bank_flag_wr(bank_flag_wr),
    .bank_flag_in(bank_flag_in),
    .bank_sel_wr(bank_sel_wr),
    .bank_sel_in(bank_sel_in),
    .reg_wr_nib(reg_wr_nib),
    .reg_wr_pair(reg_wr_pair),
    .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data),
    .ans_ff(ans_ff),
    .bit_pos_ff(bit_pos_ff),
    .nibble_immediate_ff(nibble_immediate_ff),
    .byte_immediate_ff(byte_immediate_ff),
    .port_select_ff(port_select_ff),
    .active_bank_ff(active_bank_ff),
    .bank_enable_flag_ff(bank_enable_flag_ff),
    .pairs_ff(pairs_ff)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic ck(input string nm, input logic [31:0] e,
                    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ask(input oag_mode_t m, input logic [13:0] op,
                     input logic w);
    fa = fa + 4'h1;
    pm.rom[fa] = '{mode: m, operand: op, wide: w};
    rd = 1'b1;
    req_valid = 1'b1;
    @(negedge ref_clk);
  endtask

  task automatic setbank(input logic f, input logic [3:0] s);
    rd = 1'b0;
    req_valid = 1'b0;
    bank_flag_wr = 1'b1;
    bank_flag_in = f;
    bank_sel_wr = 1'b1;
    bank_sel_in = s;
    @(negedge ref_clk);
    bank_flag_wr = 1'b0;
    bank_sel_wr = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wreg(input logic p, input logic [2:0] i,
                      input logic [7:0] d);
    rd = 1'b0;
    req_valid = 1'b0;
    reg_wr_pair = p;
    reg_wr_nib = ~p;
    reg_wr_idx = i;
    reg_wr_data = d;
    @(negedge ref_clk);
    reg_wr_pair = 1'b0;
    reg_wr_nib = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic dchk(input logic [11:0] a);
    ck("dvalid", 32'h1, 32'(ans_ff.dvalid));
    ck("daddr", 32'(a), 32'(ans_ff.daddr));
    ck("bank", 32'(a[11:8]), 32'(active_bank_ff));
  endtask

  task automatic pchk(input logic [13:0] a, input logic f);
    ck("fault", 32'(f), 32'(ans_ff.fault));
    if (!f) begin
      ck("pvalid", 32'h1, 32'(ans_ff.pvalid));
      ck("paddr", 32'(a), 32'(ans_ff.paddr));
    end
  endtask

  task automatic t_data;
    logic [3:0] bs [3] = '{4'h0, 4'h1, 4'hf};
    ck("flag", 32'h0, 32'(bank_enable_flag_ff));
    ask(OAG_M_DIRECT, 14'h007f, 1'b0);
    dchk(12'h07f);
    ask(OAG_M_DIRECT, 14'h0080, 1'b0);
    dchk(12'hf80);
    foreach (bs[i]) begin
      setbank(1'b1, bs[i]);
      ck("flag", 32'h1, 32'(bank_enable_flag_ff));
      ask(OAG_M_DIRECT, 14'h0042, 1'b1);
      dchk({bs[i], 8'h42});
      ask(OAG_M_HL, 14'h0000, 1'b0);
      dchk({bs[i], 8'h99});
      ask(OAG_M_DE, 14'h0000, 1'b0);
      dchk(12'h099);
      ask(OAG_M_DL, 14'h0000, 1'b0);
      dchk(12'h099);
    end
    setbank(1'b1, 4'h2);
    ask(OAG_M_DIRECT, 14'h0010, 1'b0);
    dchk(12'hf10);
    ask(OAG_M_DIRECT, 14'h0043, 1'b1);
    ck("fault", 32'h1, 32'(ans_ff.fault));
    setbank(1'b1, 4'h1);
    ask(OAG_M_FMEM, 14'h0005, 1'b0);
    dchk(12'hfb5);
    ask(OAG_M_FMEM, 14'h001a, 1'b0);
    dchk(12'hffa);
    ask(OAG_M_PMEM, 14'h0000, 1'b0);
    dchk(12'hfc0);
    ask(OAG_M_PMEM, 14'h003f, 1'b0);
    dchk(12'hfff);
  endtask

  task automatic t_prog;
    ask(OAG_M_FULL, 14'h3f7f, 1'b0);
    pchk(14'h3f7f, 1'b0);
    ask(OAG_M_FULL, 14'h3f80, 1'b0);
    pchk(14'h0000, 1'b1);
    ask(OAG_M_PAGE, 14'h0123, 1'b0);
    pchk(14'h2123, 1'b0);
    ask(OAG_M_SHORT, 14'h3fff, 1'b0);
    pchk(14'h07ff, 1'b0);
    ask(OAG_M_REL, 14'h0011, 1'b0);
    pchk(14'h2aad, 1'b0);
    ask(OAG_M_REL, 14'h0002, 1'b0);
    pchk(14'h2abe, 1'b0);
    ask(OAG_M_REL, 14'h0001, 1'b0);
    pchk(14'h0000, 1'b1);
    ask(OAG_M_REL, 14'h0010, 1'b0);
    pchk(14'h2acc, 1'b0);
    ask(OAG_M_REL, 14'h0000, 1'b0);
    pchk(14'h0000, 1'b1);
    ask(OAG_M_TABLE, 14'h0020, 1'b0);
    pchk(14'h0020, 1'b0);
    ask(OAG_M_TABLE, 14'h007f, 1'b0);
    pchk(14'h007e, 1'b0);
    ask(OAG_M_TABLE, 14'h001e, 1'b0);
    pchk(14'h0000, 1'b1);
  endtask

  task automatic t_fields;
    logic [13:0] ops [2] = '{14'h02f7, 14'h0108};
    foreach (ops[i]) begin
      ask(OAG_M_FULL, ops[i], 1'b0);
      ck("bitpos", 32'(ops[i][9:8]), 32'(bit_pos_ff));
      ck("nib", 32'(ops[i][3:0]), 32'(nibble_immediate_ff));
      ck("byte", 32'(ops[i][7:0]), 32'(byte_immediate_ff));
      ck("port", 32'(ops[i][2:0]), 32'(port_select_ff));
    end
    wreg(1'b1, 3'h0, 8'ha5);
    ck("pair0", 32'ha5, 32'(pairs_ff[7:0]));
    wreg(1'b1, 3'h7, 8'h3c);
    ck("pair3", 32'h3c, 32'(pairs_ff[31:24]));
    wreg(1'b0, 3'h3, 8'h0e);
    ck("pair1", 32'he, 32'(pairs_ff[15:12]));
    ck("pair0", 32'ha5, 32'(pairs_ff[7:0]));
  endtask

  task automatic t_hold;
    setbank(1'b1, 4'h1);
    ask(OAG_M_NONE, 14'h0024, 1'b0);
    ck("novalid", 32'h0, 32'({ans_ff.dvalid, ans_ff.pvalid}));
    ask(OAG_M_DIRECT, 14'h0080, 1'b0);
    dchk(12'h180);
    clk_en = 1'b0;
    ask(OAG_M_DIRECT, 14'h0011, 1'b0);
    dchk(12'h180);
    clk_en = 1'b1;
    @(negedge ref_clk);
    dchk(12'h111);
    rd = 1'b0;
    req_valid = 1'b0;
    @(negedge ref_clk);
    ck("dvalid", 32'h0, 32'(ans_ff.dvalid));
    srst = 1'b1;
    @(negedge ref_clk);
    srst = 1'b0;
    ck("flag", 32'h0, 32'(bank_enable_flag_ff));
    ask(OAG_M_DIRECT, 14'h0085, 1'b0);
    dchk(12'hf85);
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    t_data;
    t_prog;
    t_fields;
    t_hold;
    end_sim;
  end

  // watchdog against a hung sequence
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
